// *** hdl/spi_port_pkg.sv ***
// Constants, register layouts and pin bundle of the SPI port
package spi_port_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FMT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DATA = 4'h8;
    localparam logic [7:0] MODE_RST = 8'hE0;
    localparam logic [7:0] FMT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // System clock dividers of the master modes
    localparam int SYS_DIV_A = 4;
    localparam int SYS_DIV_B = 16;
    localparam int SYS_DIV_C = 64;
    localparam int BITS = 8;
    localparam int HALF_EDGES = 2 * BITS;
    // Cycles from a shift tick until the pin level it caused is sampled
    localparam int CAP_LAG = 3;

    typedef enum logic [2:0] {
        MS_DIV4, MS_DIV16, MS_DIV64, MS_SUB, MS_TMR, SL_EXT, I2C_SL, UNUSED
    } op_mode_t;

    typedef struct packed {
        op_mode_t mode;
        logic uart;
        logic [1:0] debounce;
        logic en;
        logic icf;
    } mode_ctl_t;

    typedef struct packed {
        logic [1:0] spare;
        logic pol;
        logic cap_edge;
        logic order;
        logic select_pin_enable;
        logic write_collision_flag;
        logic transfer_complete_flag;
    } fmt_ctl_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
        logic scs_n;
        logic scs_n_oe;
    } pins_t;
endpackage

// *** hdl/spi_port.sv ***
// SPI master/slave port with Avalon-MM register access
// Overview of operation
// - Mode 000..100 is master; clock sys/4, /16, /64, sub clock, timer/2.
// - Mode 101 is slave on external clock; 110 and 111 leave SPI off.
// - UART select bit set disables SPI; SPI needs it cleared.
// - Interface enable low releases all SPI pins and stops transfers.
// - Enabling the interface keeps control register contents unchanged.
// - Slave deselected mid-byte with select enabled sets incomplete and done.
// - Software writing the incomplete flag never sets the done flag.
// - Two spare format bits store and read back, reset zero.
// - Polarity bit 0 idles clock high, 1 idles clock low.
// - Edge bit with polarity picks rising or falling capture edge.
// - Shift order bit: 0 LSB first, 1 MSB first, both directions.
// - Select enable 0 floats the select pin, 1 uses it.
// - Data write during transfer is dropped and sets sticky collision flag.
// - Done flag sets at transfer end; only software clears it.
// - Master: data write starts full duplex transfer.
// - Slave shifts data out and in on external clock pulses.
// - Slave presents each outgoing bit ahead of the capture edge.
// - Port keeps working whenever its selected clock source runs; here mclk_i must run too, as every source is sampled on it.
// - Disabled port hands its pins back to other functions.
// - One 8-bit data register holds transmit and received bytes.
// - Enabled: input floats, output high, master clock idles, slave floats; slave output shows its data bit unless deselected.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
module spi_port (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire logic [spi_port_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [spi_port_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [spi_port_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Alternative shift clock sources
    input wire logic sub_clk_i,
    input wire logic timer_match_i,
    // SPI pins
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic scs_n_i,
    output spi_port_pkg::pins_t pins_o,
    output logic pin_func_o
);
    import spi_port_pkg::*;

    typedef enum logic {XF_IDLE, XF_RUN} xfer_t;

    mode_ctl_t mode_r;
    fmt_ctl_t fmt_r;
    xfer_t st_r;
    pins_t pins_r;
    pins_t pins_nxt;
    logic [7:0] data_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [4:0] half_r;
    logic [3:0] bits_r;
    logic [5:0] div_r;
    logic [CAP_LAG-1:0] cap_d_r;
    logic [CAP_LAG-1:0] last_d_r;
    logic wait_r;
    logic func_r;
    logic [DATA_W-1:0] rdata_r;
    logic [2:0] sck_s_r;
    logic [2:0] scs_s_r;
    logic [2:0] sub_s_r;
    logic [1:0] sdi_s_r;

    // Bus decode; an access completes on the edge where wait is low
    wire logic wr_go = avs_write_i & ~wait_r;
    wire logic sel_mode = avs_address_i == OFS_MODE;
    wire logic sel_fmt = avs_address_i == OFS_FMT;
    wire logic sel_data = avs_address_i == OFS_DATA;
    wire logic mode_wr = wr_go & sel_mode;
    wire logic fmt_wr = wr_go & sel_fmt;
    wire logic data_wr = wr_go & sel_data;
    wire logic [DATA_W-1:0] rd_mux = sel_mode ? DATA_W'(mode_r) :
        sel_fmt ? DATA_W'(fmt_r) : sel_data ? DATA_W'(data_r) : '0;

    // Role decode
    wire logic spi_on = mode_r.en & ~mode_r.uart
        & (mode_r.mode <= SL_EXT);
    wire logic is_slave = spi_on & (mode_r.mode == SL_EXT);
    wire logic is_master = spi_on & ~is_slave;
    wire logic busy = st_r == XF_RUN;
    wire logic m_busy = is_master & busy;
    wire logic start_m = data_wr & ~busy & is_master;

    // Master shift clock ticks, one per half period
    wire logic [5:0] half_lim =
        (mode_r.mode == MS_DIV4) ? 6'(SYS_DIV_A / 2 - 1) :
        (mode_r.mode == MS_DIV16) ? 6'(SYS_DIV_B / 2 - 1) :
        6'(SYS_DIV_C / 2 - 1);
    wire logic sys_tick = div_r == half_lim;
    wire logic sub_edge = sub_s_r[2] ^ sub_s_r[1];
    wire logic src_tick = (mode_r.mode == MS_SUB) ? sub_edge :
        (mode_r.mode == MS_TMR) ? timer_match_i : sys_tick;
    wire logic m_tick = m_busy & src_tick
        & (half_r != 5'(HALF_EDGES));
    // Even half edges lead; edge bit 1 captures on the leading edge
    wire logic m_is_cap = half_r[0] ^ fmt_r.cap_edge;
    wire logic m_cap = m_tick & m_is_cap;
    wire logic m_launch = m_tick & ~m_is_cap & (half_r != '0);
    wire logic m_last = m_tick & (half_r == 5'(HALF_EDGES - 1));
    wire logic done_m = last_d_r[CAP_LAG-1];

    // Slave side, all pins sampled through two flops first
    wire logic sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire logic sck_fall = ~sck_s_r[1] & sck_s_r[2];
    wire logic cap_rise = fmt_r.pol == fmt_r.cap_edge;
    wire logic s_sel = ~fmt_r.select_pin_enable | ~scs_s_r[1];
    wire logic s_cap = is_slave & s_sel
        & (cap_rise ? sck_rise : sck_fall);
    wire logic s_last = s_cap & busy & (bits_r == 4'(BITS - 1));
    wire logic s_abort = is_slave & fmt_r.select_pin_enable & busy
        & scs_s_r[1] & ~scs_s_r[2];
    wire logic done = done_m | (s_last & ~s_abort);

    // Shifting in the selected bit order
    wire logic cap_eff = cap_d_r[CAP_LAG-1] | s_cap;
    wire logic in_bit = sdi_s_r[1];
    wire logic tx_out = fmt_r.order ? tx_r[7] : tx_r[0];
    wire logic [7:0] tx_shift = fmt_r.order ?
        {tx_r[6:0], 1'b1} : {1'b1, tx_r[7:1]};
    wire logic [7:0] rx_shift = fmt_r.order ?
        {rx_r[6:0], in_bit} : {in_bit, rx_r[7:1]};
    wire logic tx_step = m_launch | s_cap;
    wire logic load_ok = data_wr & ~busy;
    wire logic collide = data_wr & busy;

    // Write data merged with hardware flag sets; a set beats a clear
    wire mode_ctl_t mode_wv = mode_ctl_t'(avs_writedata_i[7:0]);
    wire fmt_ctl_t fmt_wv = fmt_ctl_t'(avs_writedata_i[7:0]);
    wire mode_ctl_t mode_nxt = mode_wr ? mode_wv : mode_r;
    wire fmt_ctl_t fmt_nxt = fmt_wr ? fmt_wv : fmt_r;

    // Pin drive; SPI owns the pins only while enabled
    assign pins_nxt.sck = m_busy ? (pins_r.sck ^ m_tick)
        : ~fmt_r.pol;
    assign pins_nxt.sck_oe = is_master;
    assign pins_nxt.sdo = (m_busy | (is_slave & s_sel)) ? tx_out
        : 1'b1;
    assign pins_nxt.sdo_oe = spi_on;
    assign pins_nxt.scs_n = ~m_busy;
    assign pins_nxt.scs_n_oe = is_master & fmt_r.select_pin_enable;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
            if (avs_read_i & wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sck_s_r <= '0;
            scs_s_r <= 3'h7;
            sub_s_r <= '0;
            sdi_s_r <= '0;
        end else begin
            sck_s_r <= {sck_s_r[1:0], sck_i};
            scs_s_r <= {scs_s_r[1:0], scs_n_i};
            sub_s_r <= {sub_s_r[1:0], sub_clk_i};
            sdi_s_r <= {sdi_s_r[0], sdi_i};
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r <= mode_ctl_t'(MODE_RST);
            fmt_r <= fmt_ctl_t'(FMT_RST);
        end else begin
            mode_r <= mode_nxt;
            mode_r.icf <= mode_nxt.icf | s_abort;
            fmt_r <= fmt_nxt;
            fmt_r.transfer_complete_flag <= fmt_nxt.transfer_complete_flag | done | s_abort;
            fmt_r.write_collision_flag <= fmt_nxt.write_collision_flag | collide;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= XF_IDLE;
        end else if (!spi_on) begin
            st_r <= XF_IDLE;
        end else if (start_m || (s_cap && !busy)) begin
            st_r <= XF_RUN;
        end else if (done || s_abort) begin
            st_r <= XF_IDLE;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            half_r <= '0;
            div_r <= '0;
            cap_d_r <= '0;
            last_d_r <= '0;
        end else begin
            half_r <= start_m ? '0 : half_r + 5'(m_tick);
            div_r <= (!m_busy || sys_tick) ? '0 : div_r + 6'd1;
            // Master capture waits for its edge to return through sync
            cap_d_r <= {cap_d_r[CAP_LAG-2:0], m_cap};
            last_d_r <= {last_d_r[CAP_LAG-2:0], m_last};
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            bits_r <= '0;
        end else if (!busy || done || s_abort) begin
            bits_r <= s_cap && !busy ? 4'd1 : '0;
        end else if (s_cap) begin
            bits_r <= bits_r + 4'd1;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_r <= DATA_RST;
            rx_r <= DATA_RST;
            data_r <= DATA_RST;
        end else begin
            if (load_ok) begin
                tx_r <= avs_writedata_i[7:0];
                data_r <= avs_writedata_i[7:0];
            end else if (tx_step) begin
                tx_r <= tx_shift;
            end
            if (cap_eff) begin
                rx_r <= rx_shift;
            end
            if (done) begin
                data_r <= cap_eff ? rx_shift : rx_r;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pins_r <= '0;
            func_r <= 1'b0;
        end else begin
            pins_r <= pins_nxt;
            func_r <= spi_on;
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign pins_o = pins_r;
    assign pin_func_o = func_r;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_div4_half: assert property (
        m_busy && mode_r.mode == MS_DIV4 && $stable(mode_r)
        && $changed(pins_r.sck) && half_r != 5'(HALF_EDGES)
        |-> ##2 ($changed(pins_r.sck) || !m_busy))
        else $error("master sys/4 clock half period wrong");
    a_slave_sck_float: assert property (
        is_slave |=> !pins_r.sck_oe)
        else $error("slave drives the clock pin");
    a_uart_off: assert property (
        mode_r.uart |=> !pin_func_o && !pins_r.sdo_oe)
        else $error("SPI active in UART mode");
    a_off_release: assert property (
        !spi_on |=> !pins_r.sck_oe && !pins_r.sdo_oe
        && !pins_r.scs_n_oe && !busy)
        else $error("disabled port still holds pins");
    a_abort_flags: assert property (
        s_abort |=> mode_r.icf && fmt_r.transfer_complete_flag && !busy)
        else $error("slave abort flags missing");
    a_icf_write_only: assert property (
        mode_wr && mode_wv.icf && !fmt_r.transfer_complete_flag && !fmt_wr
        && !done && !s_abort |=> !fmt_r.transfer_complete_flag)
        else $error("incomplete flag write set done flag");
    a_idle_level: assert property (
        is_master && !busy |=> pins_r.sck == !$past(fmt_r.pol))
        else $error("clock idle level wrong");
    a_scs_float: assert property (
        !fmt_r.select_pin_enable |=> !pins_r.scs_n_oe)
        else $error("select pin driven while disabled");
    a_write_collision_flag_sticky: assert property (
        collide && !done |=> fmt_r.write_collision_flag && $stable(data_r) [*2])
        else $error("collision not flagged or data overwritten");
    a_trf_on_done: assert property (
        done |=> fmt_r.transfer_complete_flag && !busy)
        else $error("done flag not set");
    a_write_starts: assert property (
        start_m |=> busy ##1 !pins_r.scs_n)
        else $error("data write did not start transfer");
    a_sdo_idle_high: assert property (
        is_master && !busy |=> pins_r.sdo)
        else $error("idle master output not high");

    // Register storage and handshake timing
    a_spare_store: assert property (
        fmt_wr |=> fmt_r.spare == $past(fmt_wv.spare))
        else $error("spare format bits not stored");
    a_enable_keep: assert property (
        mode_wr && mode_wv.en && !mode_r.en && !fmt_wr
        |=> $stable(fmt_r[7:2]))
        else $error("format settings changed on enable");
    a_data_load: assert property (
        load_ok |=> data_r == $past(avs_writedata_i[7:0]))
        else $error("data register not loaded");
    a_bus_one_wait: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus access not answered after one wait");
    // Frame shape, pin ownership and sticky done flag
    a_master_edges: assert property (
        done_m |-> half_r == 5'(HALF_EDGES))
        else $error("master frame edge count wrong");
    a_master_sck_oe: assert property (
        is_master |=> pins_r.sck_oe)
        else $error("master clock pin not driven");
    a_sdo_deselect: assert property (
        is_slave && !s_sel |=> pins_r.sdo)
        else $error("deselected slave output not high");
    a_tmr_tick: assert property (
        m_tick && mode_r.mode == MS_TMR |=> $changed(pins_r.sck))
        else $error("timer tick did not move clock");
    a_trf_sticky: assert property (
        fmt_r.transfer_complete_flag && !fmt_wr |=> fmt_r.transfer_complete_flag)
        else $error("done flag cleared by hardware");

    c_master_done: cover property (start_m ##[1:300] done_m);
    c_timer_done: cover property (m_last && mode_r.mode == MS_TMR);
    c_slave_done: cover property (s_last && !s_abort);
    c_slave_abort: cover property (s_abort);
    c_collision: cover property (collide);
endmodule

// *** dv/spi_slave_model.sv ***
// Behavioural SPI slave standing on the far side of the master port
module spi_slave_model (
    // Serial lines
    input wire logic sck_i,
    input wire logic sdo_i,
    input wire logic scs_n_i,
    output logic sdi_o,
    // Frame settings and data
    input wire logic pol_i,
    input wire logic cap_edge_i,
    input wire logic order_i,
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o,
    output int cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cap_rise;

    // Same pol/edge pairing as the port itself
    assign cap_rise = (pol_i == cap_edge_i);

    function automatic logic pick(input int k);
        return order_i ? tx_i[7-k] : tx_i[k];
    endfunction

    initial begin
        sdi_o = 1'b1;
        rx_o = 8'h00;
        cnt_o = 0;
    end
    always @(negedge scs_n_i) begin
        cnt_o = 0;
        sdi_o = pick(0);
    end
    // Released line must not keep its last level
    always @(posedge scs_n_i) sdi_o = ~sdi_o;
    always @(sck_i) begin
        if (!scs_n_i && sck_i == cap_rise) begin
            rx_o = {rx_o[6:0], sdo_i};
            cnt_o = cnt_o + 1;
        end else if (!scs_n_i && cnt_o < 8) begin
            sdi_o = pick(cnt_o);
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the SPI port in master and slave modes
module tb_top;
    import spi_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0;
    logic reset_i = 1;
    logic [ADDR_W-1:0] adr = 4'h0;
    logic rd = 0;
    logic wr = 0;
    logic [DATA_W-1:0] wdat = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic waitreq;
    logic sub_clk = 0;
    logic tmr = 0;
    logic tb_sck = 1;
    logic tb_scs_n = 1;
    pins_t pins;
    logic func;
    logic sdi;
    logic pol = 0;
    logic cedge = 0;
    logic order = 0;
    logic [7:0] ptx = 8'h00;
    logic [7:0] prx;
    int pcnt;
    logic sck_w;
    logic sdo_w;
    logic scs_w;
    int n_fail = 0;
    int n_checks = 0;
    int tcnt = 0;

    assign sck_w = pins.sck_oe ? pins.sck : tb_sck;
    assign sdo_w = pins.sdo_oe ? pins.sdo : ~pins.sdo;
    assign scs_w = pins.scs_n_oe ? pins.scs_n : tb_scs_n;

    spi_port i_spi_port (.mclk_i(mclk_i), .reset_i(reset_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .sub_clk_i(sub_clk),
        .timer_match_i(tmr), .sck_i(sck_w), .sdi_i(sdi),
        .scs_n_i(scs_w), .pins_o(pins), .pin_func_o(func));
    spi_slave_model i_spi_slave_model (.sck_i(sck_w), .sdo_i(sdo_w),
        .scs_n_i(scs_w), .sdi_o(sdi), .pol_i(pol), .cap_edge_i(cedge),
        .order_i(order), .tx_i(ptx), .rx_o(prx), .cnt_o(pcnt));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Sub clock unrelated to the system clock
    initial begin
        forever #23 sub_clk = ~sub_clk;
    end
    always @(posedge mclk_i) begin
        tcnt <= (tcnt + 1) % 5;
        tmr <= (tcnt == 0);
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    // Edge first, so back-to-back calls never drive a signal twice
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge mclk_i);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (waitreq === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20) begin
            n_fail++;
            print_verdict();
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk_i);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        chk_reg({26'h0, pins}, 32'h0);
        chk_bit(func, 1'b0);
        rreg(OFS_MODE, q);
        chk_reg(q, 32'hE0);
        rreg(OFS_FMT, q);
        chk_reg(q, 32'h00);
        rreg(OFS_DATA, q);
        chk_reg(q, 32'h00);
        rreg(4'hC, q);
        chk_reg(q, 32'h00);
        $display("test reset done");
    endtask

    task automatic t_modes();
        logic [31:0] q;
        wreg(OFS_FMT, 8'hC0);
        wreg(OFS_MODE, 8'h02);
        rreg(OFS_FMT, q);
        chk_reg(q, 32'hC0);
        rreg(OFS_MODE, q);
        chk_reg(q, 32'h02);
        settle();
        chk_bit(func, 1'b1);
        wreg(OFS_MODE, 8'h12);
        settle();
        chk_bit(func, 1'b0);
        wreg(OFS_MODE, 8'hC2);
        settle();
        chk_bit(func, 1'b0);
        wreg(OFS_MODE, 8'hE2);
        settle();
        chk_bit(func, 1'b0);
        wreg(OFS_MODE, 8'h00);
        settle();
        chk_bit(pins.sck_oe | pins.sdo_oe, 1'b0);
        $display("test modes done");
    endtask

    task automatic t_master(input logic [2:0] m, input logic [7:0] td,
                            input logic [7:0] pd);
        logic [31:0] q;
        int i;
        wreg(OFS_MODE, {m, 5'h00});
        pol <= m[0];
        cedge <= m[1];
        order <= m[0] | m[2];
        ptx <= pd;
        wreg(OFS_FMT, {2'b00, m[0], m[1], m[0] | m[2], 3'b100});
        wreg(OFS_MODE, {m, 5'h02});
        settle();
        chk_bit(pins.sck, ~m[0]);
        wreg(OFS_DATA, td);
        if (m == 3'd0) wreg(OFS_DATA, ~td);
        for (i = 0; i < 600; i++) begin
            rreg(OFS_FMT, q);
            if (q[0] === 1'b1) break;
        end
        chk_bit(q[0], 1'b1);
        if (i == 600) print_verdict();
        chk_bit(q[1], m == 3'd0);
        rreg(OFS_DATA, q);
        chk_reg(q, {24'h0, pd});
        chk_reg({24'h0, prx}, {24'h0, order ? td : {<<{td}}});
        chk_reg(pcnt, 8);
        chk_bit(pins.sdo, 1'b1);
        chk_bit(pins.sck, ~m[0]);
        wreg(OFS_FMT, {2'b00, m[0], m[1], m[0] | m[2], 3'b100});
        rreg(OFS_FMT, q);
        chk_reg(q[1:0], 32'h0);
        $display("test master mode %0d done", m);
    endtask

    task automatic t_slave();
        logic [31:0] q;
        wreg(OFS_MODE, 8'hA0);
        wreg(OFS_FMT, 8'h04);
        wreg(OFS_MODE, 8'hA2);
        @(posedge mclk_i);
        tb_scs_n <= 1'b0;
        repeat (8) @(posedge mclk_i);
        chk_bit(pins.sck_oe, 1'b0);
        repeat (3) begin
            repeat (6) @(posedge mclk_i);
            tb_sck <= ~tb_sck;
        end
        repeat (6) @(posedge mclk_i);
        tb_scs_n <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rreg(OFS_FMT, q);
        chk_bit(q[0], 1'b1);
        rreg(OFS_MODE, q);
        chk_bit(q[0], 1'b1);
        wreg(OFS_FMT, 8'h04);
        wreg(OFS_MODE, 8'hA3);
        settle();
        rreg(OFS_FMT, q);
        chk_bit(q[0], 1'b0);
        $display("test slave abort done");
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_reset();
        t_modes();
        for (int i = 0; i < 5; i++) begin
            t_master(3'(i), 8'h3C + 8'(i), 8'hC9 - 8'(i));
        end
        t_slave();
        print_verdict();
    end
endmodule
